// ===== hdl/iopc_line_filter.sv
/*
  Per-line input filter: glitch filter on clk or debouncer on the half
  period enable. Assumes pad input already synchronous to clk.
*/
`timescale 1ns/1ns
`default_nettype none
module iopc_line_filter (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic pad_in,
  input wire logic enable,
  input wire logic slow_mode,
  input wire logic div_tick,
  output logic filt_out
);
  typedef struct packed {
    logic cand;
    logic out;
  } iopc_lf_s;
  iopc_lf_s st_reg;
  iopc_lf_s st_next;

  // A new level must hold over two sample points to pass
  always_comb begin
    st_next = st_reg;
    if (!enable) begin
      st_next.out = pad_in;
      st_next.cand = pad_in;
    end else if (!slow_mode || div_tick) begin
      st_next.cand = pad_in;
      if (st_reg.cand == pad_in) begin
        st_next.out = pad_in;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign filt_out = st_reg.out;
endmodule
`default_nettype wire

// ===== hdl/iopc_pad_config.sv
/*
  Pad configuration for 32 I/O lines: open-drain, pull-up, function
  select, input filter type and debounce divider. Assumes a plain
  register port with read data one cycle after the read strobe.
*/
// Decided for this implementation: the address-and-strobe port.
// Overview of operation
// - Writes to the protected registers are dropped while write_protect_enable is set.
// - A 1 written to opendrain_off stops open-drain driving on that line.
// - opendrain_state reads 1 for low-only driving and 0 for push-pull.
// - A 1 written to pullup_off switches the line's pull-up off.
// - A 1 written to pullup_on switches the line's pull-up on.
// - pullup_state reads 0 for an enabled pull-up and 1 for a disabled one.
// - The high and low select bits pick function A, B, C or D as 00, 01, 10, 11.
// - A 1 to filter_clock_fast_select picks the clk glitch filter for the line.
// - A 1 to filter_clock_slow_select picks the divided slow clock debouncer.
// - filter_clock_state reads 0 for glitch filter and 1 for debouncer.
// - debounce_ratio holds 14 bits and sets a period of (value+1)*2 slow clocks.
// - Filter type only matters where input_filter_state shows the filter on.
// - A 1 written to opendrain_on turns open-drain driving on for the line.
`timescale 1ns/1ns
`default_nettype none
`include "iopc_defines.svh"
module iopc_pad_config
  import iopc_pkg::*;
#(
  parameter int LINES = 32,
  parameter logic [`IOPC_SLOW_DIV_W-1:0] SLOW_DIV = `IOPC_SLOW_DIV_DEF
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [31:0] bus_addr,
  input wire logic [31:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  output logic [31:0] bus_rdata,
  input wire logic [LINES-1:0] pad_in,
  output logic [LINES-1:0] opendrain_en,
  output logic [LINES-1:0] pullup_en,
  output logic [LINES-1:0] func_a_sel,
  output logic [LINES-1:0] func_b_sel,
  output logic [LINES-1:0] func_c_sel,
  output logic [LINES-1:0] func_d_sel,
  output logic [LINES-1:0] filtered_in
);
  typedef struct packed {
    logic [LINES-1:0] od;
    logic [LINES-1:0] pu_on;
    logic [LINES-1:0] sel_lo;
    logic [LINES-1:0] sel_hi;
    logic [LINES-1:0] filt_on;
    logic [LINES-1:0] slow;
    logic [`IOPC_DIV_W-1:0] ratio;
    logic write_protect_enable;
    logic [`IOPC_SLOW_DIV_W-1:0] sdiv;
    logic stick;
    logic [31:0] rdata;
    logic [LINES-1:0] fa;
    logic [LINES-1:0] fb;
    logic [LINES-1:0] fc;
    logic [LINES-1:0] fd;
  } iopc_top_s;

  iopc_top_s st_reg;
  iopc_top_s st_next;
  iopc_bus_s bus;
  logic div_tick;
  logic [LINES-1:0] filt_w;

  function automatic logic hit(input logic [31:0] a, input logic [31:0] off);
    hit = (a == off);
  endfunction

  function automatic logic [31:0] widen(input logic [LINES-1:0] v);
    logic [31:0] r;
    r = '0;
    r[LINES-1:0] = v;
    widen = r;
  endfunction

  assign bus = '{addr: bus_addr, wdata: bus_wdata, wr: bus_wr, rd: bus_rd};

  always_comb begin
    logic pw;
    logic [LINES-1:0] wd;
    pw = 1'b0;
    wd = '0;
    st_next = st_reg;
    wd = bus.wdata[LINES-1:0];
    pw = bus.wr && !st_reg.write_protect_enable;
    // Slow clock prescaler from clk, single clock domain
    st_next.stick = 1'b0;
    if (st_reg.sdiv == '0) begin
      st_next.sdiv = SLOW_DIV;
      st_next.stick = 1'b1;
    end else begin
      st_next.sdiv = st_reg.sdiv - 1'b1;
    end
    if (pw) begin
      if (hit(bus.addr, `IOPC_OFF_OPENDRAIN_ON)) begin
        st_next.od = st_reg.od | wd;
      end
      if (hit(bus.addr, `IOPC_OFF_OPENDRAIN_OFF)) begin
        st_next.od = st_reg.od & ~wd;
      end
      // Enable sense kept in the flop so the port needs no inverter
      if (hit(bus.addr, `IOPC_OFF_PULLUP_OFF)) begin
        st_next.pu_on = st_reg.pu_on & ~wd;
      end
      if (hit(bus.addr, `IOPC_OFF_PULLUP_ON)) begin
        st_next.pu_on = st_reg.pu_on | wd;
      end
      if (hit(bus.addr, `IOPC_OFF_FUNC_SEL_LOW)) begin
        st_next.sel_lo = wd;
      end
      if (hit(bus.addr, `IOPC_OFF_FUNC_SEL_HIGH)) begin
        st_next.sel_hi = wd;
      end
      if (hit(bus.addr, `IOPC_OFF_FILT_ON)) begin
        st_next.filt_on = st_reg.filt_on | wd;
      end
      if (hit(bus.addr, `IOPC_OFF_FILT_OFF)) begin
        st_next.filt_on = st_reg.filt_on & ~wd;
      end
    end
    // Filter clock choice and divider are not write protected
    if (bus.wr) begin
      if (hit(bus.addr, `IOPC_OFF_FILT_FAST_SEL)) begin
        st_next.slow = st_reg.slow & ~wd;
      end
      if (hit(bus.addr, `IOPC_OFF_FILT_SLOW_SEL)) begin
        st_next.slow = st_reg.slow | wd;
      end
      if (hit(bus.addr, `IOPC_OFF_DEBOUNCE_RATIO)) begin
        st_next.ratio = bus.wdata[`IOPC_DIV_MSB:0];
      end
      if (hit(bus.addr, `IOPC_OFF_WRITE_PROTECT)) begin
        st_next.write_protect_enable = bus.wdata[`IOPC_WRITE_PROTECT_ENABLE_BIT];
      end
    end
    // Function one-hot outputs registered so ports come from flops
    st_next.fa = ~st_next.sel_hi & ~st_next.sel_lo;
    st_next.fb = ~st_next.sel_hi & st_next.sel_lo;
    st_next.fc = st_next.sel_hi & ~st_next.sel_lo;
    st_next.fd = st_next.sel_hi & st_next.sel_lo;
    st_next.rdata = '0;
    if (bus.rd) begin
      case (bus.addr)
        `IOPC_OFF_OPENDRAIN_STATE: st_next.rdata = widen(st_reg.od);
        `IOPC_OFF_PULLUP_STATE: st_next.rdata = widen(~st_reg.pu_on);
        `IOPC_OFF_FUNC_SEL_LOW: st_next.rdata = widen(st_reg.sel_lo);
        `IOPC_OFF_FUNC_SEL_HIGH: st_next.rdata = widen(st_reg.sel_hi);
        `IOPC_OFF_INPUT_FILTER_STATE: st_next.rdata = widen(st_reg.filt_on);
        `IOPC_OFF_FILT_CLK_STATE: st_next.rdata = widen(st_reg.slow);
        `IOPC_OFF_DEBOUNCE_RATIO: begin
          st_next.rdata[`IOPC_DIV_MSB:0] = st_reg.ratio;
        end
        `IOPC_OFF_WRITE_PROTECT: begin
          st_next.rdata[`IOPC_WRITE_PROTECT_ENABLE_BIT] = st_reg.write_protect_enable;
        end
        `IOPC_OFF_PAD_IN: st_next.rdata = widen(filt_w);
        default: st_next.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_reg <= '0;
      st_reg.fa <= '1;
      st_reg.pu_on <= '1;
    end else begin
      st_reg <= st_next;
    end
  end

  iopc_slow_tick #(.DIV_W(`IOPC_DIV_W)) u_tick (
    .clk(clk),
    .rst_b(rst_b),
    .slow_tick(st_reg.stick),
    .ratio(st_reg.ratio),
    .div_tick(div_tick)
  );

  // One filter per line; outputs are flops inside the filter
  genvar gi;
  generate
    for (gi = 0; gi < LINES; gi++) begin : g_line
      iopc_line_filter u_filt (
        .clk(clk),
        .rst_b(rst_b),
        .pad_in(pad_in[gi]),
        .enable(st_reg.filt_on[gi]),
        .slow_mode(st_reg.slow[gi]),
        .div_tick(div_tick),
        .filt_out(filt_w[gi])
      );
    end
  endgenerate

  assign filtered_in = filt_w;
  assign bus_rdata = st_reg.rdata;
  assign opendrain_en = st_reg.od;
  assign pullup_en = st_reg.pu_on;
  assign func_a_sel = st_reg.fa;
  assign func_b_sel = st_reg.fb;
  assign func_c_sel = st_reg.fc;
  assign func_d_sel = st_reg.fd;
endmodule
`default_nettype wire

// ===== hdl/iopc_slow_tick.sv
/*
  Divided slow clock enable. Assumes slow_tick is a one-cycle enable at
  the slow clock rate, derived from clk by the parent.
*/
`timescale 1ns/1ns
`default_nettype none
`include "iopc_defines.svh"
module iopc_slow_tick
  import iopc_pkg::*;
#(
  parameter int DIV_W = `IOPC_DIV_W
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic slow_tick,
  input wire logic [DIV_W-1:0] ratio,
  output logic div_tick
);
  typedef struct packed {
    logic [DIV_W-1:0] cnt;
    logic tick;
  } iopc_st_s;
  iopc_st_s st_reg;
  iopc_st_s st_next;

  // Half period is ratio+1 slow ticks, so full period is (ratio+1)*2
  always_comb begin
    st_next = st_reg;
    st_next.tick = 1'b0;
    if (slow_tick) begin
      if (st_reg.cnt >= ratio) begin
        st_next.cnt = '0;
        st_next.tick = 1'b1;
      end else begin
        st_next.cnt = st_reg.cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign div_tick = st_reg.tick;
endmodule
`default_nettype wire

// ===== inc/iopc_defines.svh
/*
  Offsets, field positions, reset values and sizes for the pad
  configuration block. Assumes word-aligned byte addresses on a plain
  register port.
*/
`ifndef IOPC_DEFINES_SVH
`define IOPC_DEFINES_SVH

`define IOPC_ADDR_W 32
`define IOPC_OFF_OPENDRAIN_ON 32'hfffff450
`define IOPC_OFF_OPENDRAIN_OFF 32'hfffff454
`define IOPC_OFF_OPENDRAIN_STATE 32'hfffff458
`define IOPC_OFF_PULLUP_OFF 32'hfffff460
`define IOPC_OFF_PULLUP_ON 32'hfffff464
`define IOPC_OFF_PULLUP_STATE 32'hfffff468
`define IOPC_OFF_FUNC_SEL_LOW 32'hfffff46c
`define IOPC_OFF_FUNC_SEL_HIGH 32'hfffff470
`define IOPC_OFF_FILT_ON 32'hfffff474
`define IOPC_OFF_FILT_OFF 32'hfffff478
`define IOPC_OFF_INPUT_FILTER_STATE 32'hfffff47c
`define IOPC_OFF_FILT_FAST_SEL 32'hfffff480
`define IOPC_OFF_FILT_SLOW_SEL 32'hfffff484
`define IOPC_OFF_FILT_CLK_STATE 32'hfffff488
`define IOPC_OFF_DEBOUNCE_RATIO 32'hfffff48c
`define IOPC_OFF_WRITE_PROTECT 32'hfffff4e4
`define IOPC_OFF_PAD_IN 32'hfffff4e8
`define IOPC_DIV_W 14
`define IOPC_DIV_MSB 13
`define IOPC_WRITE_PROTECT_ENABLE_BIT 0
`define IOPC_RST_ZERO 32'h00000000
`define IOPC_RST_ONES 32'hffffffff
`define IOPC_RST_DIV 14'h0000
`define IOPC_SLOW_DIV_W 10
`define IOPC_SLOW_DIV_DEF 10'h262

`endif

// ===== inc/iopc_pkg.sv
/*
  Types for the pad configuration block. Assumes 32 lines per port.
*/
package iopc_pkg;
  typedef logic [31:0] iopc_word_t;
  typedef enum logic [3:0] {
    IOPC_FN_A = 4'h1,
    IOPC_FN_B = 4'h2,
    IOPC_FN_C = 4'h4,
    IOPC_FN_D = 4'h8
  } iopc_func_e;
  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } iopc_bus_s;
endpackage

// ===== verification/iopc_pad_config_sva.sv
/*
  Port assertions for the pad configuration block.
  Assumes a bind from the bench top; sees the protect bit via bus writes.
*/
`timescale 1ns/1ns
`default_nettype none
`include "iopc_defines.svh"
module iopc_pad_config_sva (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [31:0] bus_addr,
  input wire logic [31:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  input wire logic [31:0] bus_rdata,
  input wire logic [31:0] opendrain_en,
  input wire logic [31:0] pullup_en,
  input wire logic [31:0] func_a_sel,
  input wire logic [31:0] func_b_sel,
  input wire logic [31:0] func_c_sel,
  input wire logic [31:0] func_d_sel
);
  logic wp_reg;
  logic ok;
  // Mirror of the protect bit; it has no port of its own
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wp_reg <= 1'b0;
    end else if (bus_wr && bus_addr == `IOPC_OFF_WRITE_PROTECT) begin
      wp_reg <= bus_wdata[`IOPC_WRITE_PROTECT_ENABLE_BIT];
    end
  end
  assign ok = bus_wr && !wp_reg;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  a_wp_drop: assert property (
    bus_wr && wp_reg |=> $stable(pullup_en) && $stable(opendrain_en)
    && $stable(func_a_sel) && $stable(func_d_sel))
    else $error("Protected write changed a pad setting");
  a_od_off: assert property (
    ok && bus_addr == `IOPC_OFF_OPENDRAIN_OFF |=> (opendrain_en & $past(bus_wdata)) == 0
    && (opendrain_en & ~$past(bus_wdata)) == ($past(opendrain_en) & ~$past(bus_wdata)))
    else $error("Open-drain clear wrong");
  a_od_on: assert property (
    ok && bus_addr == `IOPC_OFF_OPENDRAIN_ON
    |=> (opendrain_en & $past(bus_wdata)) == $past(bus_wdata))
    else $error("Open-drain set wrong");
  a_pu_off: assert property (
    ok && bus_addr == `IOPC_OFF_PULLUP_OFF |=> (pullup_en & $past(bus_wdata)) == 0)
    else $error("Pull-up clear wrong");
  a_pu_on: assert property (
    ok && bus_addr == `IOPC_OFF_PULLUP_ON
    |=> (pullup_en & $past(bus_wdata)) == $past(bus_wdata))
    else $error("Pull-up set wrong");
  a_od_read: assert property (
    bus_rd && bus_addr == `IOPC_OFF_OPENDRAIN_STATE |=> bus_rdata == opendrain_en)
    else $error("Open-drain state readback wrong");
  a_pu_read: assert property (
    bus_rd && bus_addr == `IOPC_OFF_PULLUP_STATE |=> bus_rdata == ~pullup_en)
    else $error("Pull-up state readback wrong");
  a_fn_read: assert property (
    bus_rd && bus_addr == `IOPC_OFF_FUNC_SEL_LOW |=> bus_rdata == (func_b_sel | func_d_sel))
    else $error("Low select disagrees with function outputs");
  a_fn_onehot: assert property (
    (func_a_sel | func_b_sel | func_c_sel | func_d_sel) == '1
    && ((func_a_sel & func_b_sel) | (func_c_sel & func_d_sel)
    | ((func_a_sel | func_b_sel) & (func_c_sel | func_d_sel))) == 0)
    else $error("Function select not one-hot");
  a_ratio_read: assert property (
    bus_rd && bus_addr == `IOPC_OFF_DEBOUNCE_RATIO |=> bus_rdata[31:14] == 0)
    else $error("Ratio upper bits not zero");
  c_wp: cover property (bus_wr && wp_reg);
  c_pu: cover property (ok && bus_addr == `IOPC_OFF_PULLUP_OFF);
  c_fn: cover property (bus_rd && bus_addr == `IOPC_OFF_FUNC_SEL_LOW);
endmodule
`default_nettype wire

// ===== verification/iopc_pad_model.sv
/*
  Pad side: raw line levels, inverted for as many cycles as glitch is held.
  Assumes the bench changes lvl and glitch just after rising edges.
*/
`timescale 1ns/1ns
`default_nettype none
module iopc_pad_model
  import iopc_pkg::*;
(
  input wire logic clk,
  input wire iopc_word_t lvl,
  input wire iopc_word_t glitch,
  output var iopc_word_t pad_in = '0
);
  // Registered so pads only move at edges, as the block assumes
  always @(posedge clk) begin
    pad_in <= lvl ^ glitch;
  end
endmodule
`default_nettype wire

// ===== verification/tb_top.sv
/*
  Bench for the pad configuration block: register traffic and filters.
  Assumes the design files and the pad model are compiled first.
*/
`timescale 1ns/1ns
`default_nettype none
`include "iopc_defines.svh"
module tb_top
  import iopc_pkg::*;
;
  logic clk = 0, rst_b = 0, bus_wr = 0, bus_rd = 0;
  iopc_word_t bus_addr = '0, bus_wdata = '0, lvl = '0, glitch = '0;
  iopc_word_t bus_rdata, pad_in, od_en, pu_en, fa, fb, fc, fd, filt;
  iopc_word_t od, pu, lo, hi, m, m2, acc, sl;
  int seed = 56721, fail_count = 0, checks_done = 0, cyc = 0;
  always #25 clk = ~clk;
  // Small divider keeps the slow tick short in simulation
  iopc_pad_config #(.SLOW_DIV(10'h002)) iopc_pad_config_inst (.clk, .rst_b, .bus_addr,
    .bus_wdata, .bus_wr, .bus_rd, .bus_rdata, .pad_in, .opendrain_en(od_en), .pullup_en(pu_en),
    .func_a_sel(fa), .func_b_sel(fb), .func_c_sel(fc), .func_d_sel(fd), .filtered_in(filt));
  iopc_pad_model iopc_pad_model_inst (.clk, .lvl, .glitch, .pad_in);
  function automatic iopc_word_t fs(iopc_word_t h, iopc_word_t l, int k);
    return (k[1] ? h : ~h) & (k[0] ? l : ~l);
  endfunction
  task automatic chk(input string n, input iopc_word_t e, input iopc_word_t s);
    checks_done++;
    if (s !== e) begin
      fail_count++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input iopc_word_t a, input iopc_word_t d);
    @(posedge clk);
    bus_addr <= a;
    bus_wdata <= d;
    bus_wr <= 1'b1;
    @(posedge clk);
    bus_wr <= 1'b0;
    @(negedge clk);
  endtask
  task automatic rd(input string n, input iopc_word_t a, input iopc_word_t e);
    @(posedge clk);
    bus_addr <= a;
    bus_rd <= 1'b1;
    @(posedge clk);
    bus_rd <= 1'b0;
    @(negedge clk);
    chk(n, e, bus_rdata);
  endtask
  task automatic finish_test;
    $display("Checks %0d errors %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // Ceiling well above the roughly 180 cycles the sequence needs
  always @(posedge clk) begin
    cyc++;
    if (cyc == 4000) begin
      fail_count++;
      finish_test;
    end
  end
  initial begin
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    @(negedge clk);
    chk("pullup_en", '1, pu_en);
    chk("func_a_sel", '1, fa);
    rd("pullup_state", `IOPC_OFF_PULLUP_STATE, 32'h0);
    rd("unmapped", 32'hfffff490, 32'h0);
    od = '0;
    pu = '1;
    sl = '0;
    for (int i = 0; i < 4; i++) begin
      m = $random(seed);
      m2 = $random(seed);
      wr(`IOPC_OFF_OPENDRAIN_ON, m);
      wr(`IOPC_OFF_OPENDRAIN_OFF, m2);
      od = (od | m) & ~m2;
      chk("opendrain_en", od, od_en);
      rd("opendrain_state", `IOPC_OFF_OPENDRAIN_STATE, od);
      wr(`IOPC_OFF_PULLUP_OFF, m);
      wr(`IOPC_OFF_PULLUP_ON, m2);
      pu = (pu & ~m) | m2;
      chk("pullup_en", pu, pu_en);
      rd("pullup_state", `IOPC_OFF_PULLUP_STATE, ~pu);
      lo = m ^ m2;
      hi = m2;
      wr(`IOPC_OFF_FUNC_SEL_LOW, lo);
      wr(`IOPC_OFF_FUNC_SEL_HIGH, hi);
      rd("select_low", `IOPC_OFF_FUNC_SEL_LOW, lo);
      chk("func_a_sel", fs(hi, lo, 0), fa);
      chk("func_b_sel", fs(hi, lo, 1), fb);
      chk("func_c_sel", fs(hi, lo, 2), fc);
      chk("func_d_sel", fs(hi, lo, 3), fd);
      wr(`IOPC_OFF_FILT_SLOW_SEL, m);
      wr(`IOPC_OFF_FILT_FAST_SEL, m2);
      // Slow choice accumulates over the loop
      sl = (sl | m) & ~m2;
      rd("filter_clock_state", `IOPC_OFF_FILT_CLK_STATE, sl);
    end
    wr(`IOPC_OFF_WRITE_PROTECT, 32'h1);
    wr(`IOPC_OFF_PULLUP_OFF, '1);
    wr(`IOPC_OFF_OPENDRAIN_ON, '1);
    wr(`IOPC_OFF_FUNC_SEL_HIGH, ~hi);
    chk("pullup_en", pu, pu_en);
    chk("opendrain_en", od, od_en);
    rd("select_high", `IOPC_OFF_FUNC_SEL_HIGH, hi);
    wr(`IOPC_OFF_WRITE_PROTECT, 32'h0);
    wr(`IOPC_OFF_FUNC_SEL_HIGH, ~hi);
    rd("select_high", `IOPC_OFF_FUNC_SEL_HIGH, ~hi);
    wr(`IOPC_OFF_DEBOUNCE_RATIO, '1);
    rd("debounce_ratio", `IOPC_OFF_DEBOUNCE_RATIO, 32'h3fff);
    wr(`IOPC_OFF_FILT_FAST_SEL, '1);
    wr(`IOPC_OFF_FILT_ON, 32'h1);
    rd("input_filter_state", `IOPC_OFF_INPUT_FILTER_STATE, 32'h1);
    @(posedge clk);
    lvl <= 32'h3;
    repeat (6) @(posedge clk);
    glitch <= 32'h3;
    @(posedge clk);
    glitch <= 32'h0;
    acc = '1;
    // Line 0 filtered, line 1 not: only line 1 shows the dip
    repeat (4) begin
      @(negedge clk);
      acc &= filt;
    end
    chk("filtered_in", 32'h1, acc & 32'h3);
    // Ratio 0: debounce samples three clocks apart, so a two-cycle dip is lost
    wr(`IOPC_OFF_DEBOUNCE_RATIO, 32'h0);
    wr(`IOPC_OFF_FILT_SLOW_SEL, 32'h1);
    rd("filter_clock_state", `IOPC_OFF_FILT_CLK_STATE, 32'h1);
    @(posedge clk);
    glitch <= 32'h1;
    repeat (2) @(posedge clk);
    glitch <= 32'h0;
    acc = '1;
    repeat (6) begin
      @(negedge clk);
      acc &= filt;
    end
    chk("filtered_in", 32'h1, acc & 32'h1);
    @(posedge clk);
    lvl <= 32'h2;
    repeat (16) @(posedge clk);
    @(negedge clk);
    chk("filtered_in", 32'h2, filt & 32'h3);
    finish_test;
  end
endmodule
bind iopc_pad_config iopc_pad_config_sva iopc_pad_config_sva_inst (.clk, .rst_b, .bus_addr,
  .bus_wdata, .bus_wr, .bus_rd, .bus_rdata, .opendrain_en, .pullup_en, .func_a_sel, .func_b_sel,
  .func_c_sel, .func_d_sel);
`default_nettype wire
